// ---- shared/kpomc_map.vh ----
// constants for the keypad overlay mode controller
//
// Contract
// - a press of the mode key lights the mode indicator, except one that hands on the first number of a jump.
// - while the mode indicator is lit, keys are read as the red command labels.
// - pause, out, point, jump and speed light the enter indicator and start numeric entry.
// - while the enter indicator is lit, keys are read as digits and build up a value.
// - in numeric entry the record key clears the value typed so far.
// - in numeric entry the mode key hands the value on; it ends entry and darkens enter except after the first number of a jump.
// - in train or move mode, keys are read as joint keys and the record key.
// - after reset the keypad is in train mode without any key press.
// - speed takes 0 to 15 and starts at 5 after reset.
`ifndef KPOMC_MAP_VH
`define KPOMC_MAP_VH

// register byte offsets
`define KPOMC_OFS_CTRL 4'h0
`define KPOMC_OFS_STATUS 4'h4
`define KPOMC_OFS_VALUE 4'h8
`define KPOMC_OFS_LAST 4'hC

// field positions
`define KPOMC_CTRL_EN 0
`define KPOMC_ST_MODE_LED 3
`define KPOMC_ST_ENTER_LED 4
`define KPOMC_ST_SPEED_LSB 8

// reset values
`define KPOMC_RST_CTRL 1'h1
`define KPOMC_RST_SPEED 4'h5
`define KPOMC_SPEED_MAX 8'h0F
`define KPOMC_VALUE_MAX 10'h0FF

// timing: debounce sample period
`define KPOMC_DB_MS 5
`define KPOMC_CLK_KHZ 100000
`define KPOMC_DB_CYC (`KPOMC_DB_MS * `KPOMC_CLK_KHZ)

// states
`define KPOMC_S_TRAIN 3'h0
`define KPOMC_S_MOVE 3'h1
`define KPOMC_S_CMD 3'h2
`define KPOMC_S_ENTRY 3'h3
`define KPOMC_S_RUN 3'h4

// key positions; digits sit on keys 2..11 as numerals 0..9
`define KPOMC_K_MODE 4'h0
`define KPOMC_K_REC 4'h1
`define KPOMC_K_DIG0 4'h2
`define KPOMC_K_DIG9 4'hB

// red command keys
`define KPOMC_C_TRAIN 4'h2
`define KPOMC_C_STEP 4'h3
`define KPOMC_C_PAUSE 4'h4
`define KPOMC_C_RUN 4'h5
`define KPOMC_C_OUT 4'h6
`define KPOMC_C_POINT 4'h7
`define KPOMC_C_JUMP 4'h8
`define KPOMC_C_SPEED 4'h9
`define KPOMC_C_MOVE 4'hA
`define KPOMC_C_CLEAR 4'hB
`define KPOMC_C_ZERO 4'hC
`define KPOMC_C_STOP 4'hD
// code given to the first number of a jump
`define KPOMC_C_JCOND 4'hF

`endif

// ---- rtl/kpomc_top.v ----
// keypad overlay mode controller with a wishbone register slave
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`include "kpomc_map.vh"

module kpomc_top #(
  parameter DB_CYCLES = `KPOMC_DB_CYC // debounce sample period in cycles
) (
  input wire clk_i, // 100 MHz system clock
  input wire rst_i, // synchronous reset, active high
  input wire [15:0] key_i, // raw key lines, high while pressed
  output reg mode_led_o, // red mode indicator
  output reg enter_led_o, // yellow enter indicator
  output reg joint_evt_o, // pulse: joint key or record in train/move
  output reg [3:0] joint_key_o, // key position of the joint event
  output reg move_mode_o, // high in move mode, low in train mode
  output reg cmd_evt_o, // pulse: command issued
  output reg [3:0] cmd_code_o, // command code of the event
  output reg [7:0] cmd_value_o, // value handed with the command
  output reg [3:0] speed_o, // current speed setting
  input wire [3:0] wb_adr_i, // wishbone byte address
  input wire [31:0] wb_dat_i, // wishbone write data
  input wire [3:0] wb_sel_i, // wishbone byte lanes
  input wire wb_we_i, // wishbone write
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  output reg [31:0] wb_dat_o, // wishbone read data
  output reg wb_ack_o // wishbone acknowledge
);

  // true for the keys that open numeric entry
  function is_entry_cmd;
    input [3:0] k;
    begin
      is_entry_cmd = (k == `KPOMC_C_PAUSE) || (k == `KPOMC_C_OUT) ||
        (k == `KPOMC_C_POINT) || (k == `KPOMC_C_JUMP) || (k == `KPOMC_C_SPEED);
    end
  endfunction

  // lowest pressed key position
  function [3:0] first_key;
    input [15:0] v;
    integer i;
    begin
      first_key = 4'h0;
      for (i = 15; i >= 0; i = i - 1) begin
        if (v[i]) begin
          first_key = i[3:0];
        end
      end
    end
  endfunction

  // shift one decimal digit into the entry value, holding at the ceiling;
  // the sum is formed wide so that a large value cannot wrap below the ceiling
  function [9:0] acc_push;
    input [9:0] a;
    input [3:0] d;
    reg [13:0] t;
    begin
      t = ({4'h0, a} * 14'h00A) + {10'h000, d};
      if (t > {4'h0, `KPOMC_VALUE_MAX}) begin
        acc_push = `KPOMC_VALUE_MAX;
      end else begin
        acc_push = t[9:0];
      end
    end
  endfunction

  reg [15:0] key_s1;
  reg [15:0] key_s2;
  reg [15:0] samp_a;
  reg [15:0] key_db;
  reg [15:0] key_db_d;
  reg [19:0] db_cnt;
  reg db_tick;
  reg ctrl_en;
  reg [2:0] state;
  reg [3:0] pend_cmd;
  reg jump_second;
  reg [9:0] acc;
  reg [3:0] last_key;
  reg [2:0] next_state;
  reg [9:0] next_acc;
  reg [3:0] next_speed;
  reg next_cmd_evt;
  reg [3:0] next_cmd_code;
  reg next_joint_evt;
  reg next_jump_second;
  reg [3:0] next_pend;
  wire [15:0] press;
  wire any_press;
  wire [3:0] pk;
  wire [3:0] digit;
  wire mode_held;
  wire wb_req;
  wire wb_wr;
  wire wb_rd;

  // two-flop synchroniser for the key lines
  always @(posedge clk_i) begin
    if (rst_i) begin
      key_s1 <= 16'h0000;
      key_s2 <= 16'h0000;
    end else begin
      key_s1 <= key_i;
      key_s2 <= key_s1;
    end
  end

  // sample tick for the debouncer
  always @(posedge clk_i) begin
    if (rst_i) begin
      db_cnt <= 20'h00000;
      db_tick <= 1'b0;
    end else if (db_cnt == DB_CYCLES[19:0] - 20'h00001) begin
      db_cnt <= 20'h00000;
      db_tick <= 1'b1;
    end else begin
      db_cnt <= db_cnt + 20'h00001;
      db_tick <= 1'b0;
    end
  end

  // a key changes only after two equal samples one period apart
  always @(posedge clk_i) begin
    if (rst_i) begin
      samp_a <= 16'h0000;
      key_db <= 16'h0000;
      key_db_d <= 16'h0000;
    end else begin
      key_db_d <= key_db;
      if (db_tick) begin
        samp_a <= key_s2;
        key_db <= (samp_a & key_s2) | (key_db & (samp_a | key_s2));
      end
    end
  end

  // one press event per debounced rising edge
  assign press = key_db & ~key_db_d;
  assign any_press = ctrl_en && (press != 16'h0000);
  assign pk = first_key(press);
  assign digit = pk - `KPOMC_K_DIG0;
  assign mode_held = key_db[`KPOMC_K_MODE];

  // overlay state machine: how the next press is read
  always @* begin
    next_state = state;
    next_acc = acc;
    next_speed = speed_o;
    next_cmd_evt = 1'b0;
    next_cmd_code = cmd_code_o;
    next_joint_evt = 1'b0;
    next_jump_second = jump_second;
    next_pend = pend_cmd;
    if (any_press) begin
      case (state)
        `KPOMC_S_TRAIN, `KPOMC_S_MOVE: begin
          if (pk == `KPOMC_K_MODE) begin
            next_state = `KPOMC_S_CMD;
          end else begin
            next_joint_evt = 1'b1;
          end
        end
        `KPOMC_S_RUN: begin
          if (pk == `KPOMC_K_MODE) begin
            next_state = `KPOMC_S_CMD;
          end else if (pk == `KPOMC_C_STOP) begin
            next_state = `KPOMC_S_CMD;
            next_cmd_evt = 1'b1;
            next_cmd_code = pk;
          end
        end
        `KPOMC_S_CMD: begin
          if (is_entry_cmd(pk)) begin
            next_state = `KPOMC_S_ENTRY;
            next_pend = pk;
            next_acc = 10'h000;
            next_jump_second = 1'b0;
          end else if (pk == `KPOMC_C_TRAIN) begin
            next_state = `KPOMC_S_TRAIN;
            next_cmd_evt = 1'b1;
            next_cmd_code = pk;
          end else if (pk == `KPOMC_C_MOVE) begin
            next_state = `KPOMC_S_MOVE;
            next_cmd_evt = 1'b1;
            next_cmd_code = pk;
          end else if (pk == `KPOMC_C_RUN) begin
            next_state = `KPOMC_S_RUN;
            next_cmd_evt = 1'b1;
            next_cmd_code = pk;
          end else if (pk == `KPOMC_C_STEP || pk == `KPOMC_C_STOP) begin
            next_cmd_evt = 1'b1;
            next_cmd_code = pk;
          end else if ((pk == `KPOMC_C_CLEAR || pk == `KPOMC_C_ZERO) && mode_held) begin
            next_cmd_evt = 1'b1;
            next_cmd_code = pk;
          end
        end
        `KPOMC_S_ENTRY: begin
          if (pk == `KPOMC_K_REC) begin
            next_acc = 10'h000;
          end else if (pk == `KPOMC_K_MODE) begin
            next_cmd_evt = 1'b1;
            if (pend_cmd == `KPOMC_C_JUMP && !jump_second) begin
              next_cmd_code = `KPOMC_C_JCOND;
              next_jump_second = 1'b1;
              next_acc = 10'h000;
            end else begin
              next_cmd_code = pend_cmd;
              next_state = `KPOMC_S_CMD;
              if (pend_cmd == `KPOMC_C_SPEED && acc <= {2'b00, `KPOMC_SPEED_MAX}) begin
                next_speed = acc[3:0];
              end
            end
          end else if (pk >= `KPOMC_K_DIG0 && pk <= `KPOMC_K_DIG9) begin
            next_acc = acc_push(acc, digit);
          end
        end
        default: begin
          next_state = `KPOMC_S_TRAIN;
        end
      endcase
    end
  end

  // state, lights and event outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= `KPOMC_S_TRAIN;
      acc <= 10'h000;
      pend_cmd <= 4'h0;
      jump_second <= 1'b0;
      speed_o <= `KPOMC_RST_SPEED;
      mode_led_o <= 1'b0;
      enter_led_o <= 1'b0;
      move_mode_o <= 1'b0;
      cmd_evt_o <= 1'b0;
      cmd_code_o <= 4'h0;
      cmd_value_o <= 8'h00;
      joint_evt_o <= 1'b0;
      joint_key_o <= 4'h0;
      last_key <= 4'h0;
    end else begin
      state <= next_state;
      acc <= next_acc;
      pend_cmd <= next_pend;
      jump_second <= next_jump_second;
      speed_o <= next_speed;
      mode_led_o <= (next_state == `KPOMC_S_CMD);
      enter_led_o <= (next_state == `KPOMC_S_ENTRY);
      move_mode_o <= (next_state == `KPOMC_S_MOVE);
      cmd_evt_o <= next_cmd_evt;
      cmd_code_o <= next_cmd_code;
      if (next_cmd_evt) begin
        cmd_value_o <= acc[7:0];
      end
      joint_evt_o <= next_joint_evt;
      if (next_joint_evt) begin
        joint_key_o <= pk;
      end
      if (any_press) begin
        last_key <= pk;
      end
    end
  end

  // wishbone classic slave, ack one cycle after the strobe
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;
  assign wb_rd = wb_req && !wb_we_i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_en <= `KPOMC_RST_CTRL;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_wr && wb_adr_i == `KPOMC_OFS_CTRL && wb_sel_i[0]) begin
        ctrl_en <= wb_dat_i[`KPOMC_CTRL_EN];
      end
      if (wb_rd) begin
        case (wb_adr_i)
          `KPOMC_OFS_CTRL: begin
            wb_dat_o <= {31'h0000000, ctrl_en};
          end
          `KPOMC_OFS_STATUS: begin
            wb_dat_o <= {20'h00000, speed_o, 3'h0, enter_led_o, mode_led_o, state};
          end
          `KPOMC_OFS_VALUE: begin
            wb_dat_o <= {22'h00000, acc};
          end
          `KPOMC_OFS_LAST: begin
            wb_dat_o <= {16'h0000, last_key, pend_cmd, cmd_value_o};
          end
          default: begin
            wb_dat_o <= 32'h00000000;
          end
        endcase
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

endmodule // kpomc_top

// ---- sim/kpomc_sva.sv ----
// assertions for the keypad overlay mode controller
`timescale 1ns/1ns
module kpomc_sva (
  input wire clk_i, // clock
  input wire rst_i, // reset
  input wire mode_led_o, // mode light
  input wire enter_led_o, // enter light
  input wire joint_evt_o, // joint pulse
  input wire move_mode_o, // move level
  input wire cmd_evt_o, // command pulse
  input wire [3:0] cmd_code_o, // command code
  input wire [7:0] cmd_value_o, // command value
  input wire [3:0] speed_o, // speed
  input wire wb_cyc_i, // cycle
  input wire wb_stb_i, // strobe
  input wire [31:0] wb_dat_o, // read data
  input wire wb_ack_o // acknowledge
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // overlays, pulses and speed updates
  a_lights_excl: assert property (!(mode_led_o && enter_led_o))
    else $error("both lights on");
  a_joint_overlay: assert property (joint_evt_o |-> !mode_led_o && !enter_led_o)
    else $error("joint event under a light");
  a_joint_once: assert property (joint_evt_o |=> !joint_evt_o)
    else $error("joint pulse too long");
  a_cmd_once: assert property (cmd_evt_o |=> !cmd_evt_o)
    else $error("command pulse too long");
  a_reset_train: assert property ($fell(rst_i) |-> speed_o == 4'h5 && !mode_led_o
    && !enter_led_o && !move_mode_o) else $error("bad state after reset");
  a_speed_cause: assert property ($changed(speed_o) |-> cmd_code_o == 4'h9
    && cmd_value_o <= 8'h0F && cmd_value_o[3:0] == speed_o) else $error("speed change");
  a_enter_end: assert property ($fell(enter_led_o) |-> ##[0:1] (cmd_evt_o || $past(cmd_evt_o)))
    else $error("entry ended without command");
  a_enter_back: assert property ($fell(enter_led_o) |-> ##[0:1] mode_led_o)
    else $error("entry ended without mode light");
  // register bus answer
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
endmodule // kpomc_sva

bind kpomc_top kpomc_sva u_kpomc_sva (.clk_i, .rst_i, .mode_led_o, .enter_led_o, .joint_evt_o,
  .move_mode_o, .cmd_evt_o, .cmd_code_o, .cmd_value_o, .speed_o, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o);

// ---- sim/kpomc_operator.sv ----
// operator model: presses one key, or the mode key with a second key beside it, holds them, then lets go
`timescale 1ns/1ns
module kpomc_operator (
  input wire clk_i, // clock
  output reg [15:0] key_o // key lines, high while pressed
);
  initial key_o = 16'h0000;
  // release is held long enough to be debounced before the next press
  task press(input [3:0] k, input integer hold);
    begin
      @(posedge clk_i) key_o <= 16'h0001 << k;
      repeat (hold) @(posedge clk_i);
      key_o <= 16'h0000;
      repeat (40) @(posedge clk_i);
    end
  endtask
  // hold the mode key down, then press a second key beside it
  task chord(input [3:0] k);
    begin
      @(posedge clk_i) key_o <= 16'h0001;
      repeat (30) @(posedge clk_i);
      key_o <= 16'h0001 | (16'h0001 << k);
      repeat (30) @(posedge clk_i);
      key_o <= 16'h0000;
      repeat (40) @(posedge clk_i);
    end
  endtask
endmodule // kpomc_operator

// ---- sim/kpomc_top_tb.sv ----
// self-checking bench for the keypad overlay mode controller
`timescale 1ns/1ns
`include "kpomc_map.vh"
module kpomc_top_tb;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [3:0] wb_adr_i = 4'h0;
  reg [31:0] wb_dat_i = 32'h0;
  reg wb_we_i = 1'b0;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg [3:0] wb_sel_i = 4'hF;
  wire [15:0] key_i;
  wire mode_led_o, enter_led_o, joint_evt_o, move_mode_o, cmd_evt_o, wb_ack_o;
  wire [3:0] joint_key_o, cmd_code_o, speed_o;
  wire [7:0] cmd_value_o;
  wire [31:0] wb_dat_o;
  reg [31:0] q;
  reg [11:0] ecmd = {4'h4, 4'h6, 4'h7};
  integer fail_count = 0, checks_done = 0, cyc = 0, nj = 0, nc = 0, n0, i;
  always #5 clk_i = ~clk_i;
  kpomc_top #(.DB_CYCLES(4)) u_kpomc_top (.clk_i(clk_i), .rst_i(rst_i), .key_i(key_i),
    .mode_led_o(mode_led_o), .enter_led_o(enter_led_o), .joint_evt_o(joint_evt_o),
    .joint_key_o(joint_key_o), .move_mode_o(move_mode_o), .cmd_evt_o(cmd_evt_o),
    .cmd_code_o(cmd_code_o), .cmd_value_o(cmd_value_o), .speed_o(speed_o),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  kpomc_operator u_op (.clk_i(clk_i), .key_o(key_i));
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [79:0] w, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %0s exp %h got %h", w, e, g);
      end
    end
  endtask
  // one classic wishbone cycle, held until ack
  task wb(input we, input [3:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task key(input [3:0] k);
    u_op.press(k, 30);
  endtask
  // speed entry of two digits ended by the mode key
  task spd(input [3:0] t, input [3:0] o);
    begin
      key(`KPOMC_C_SPEED);
      key(t + 4'h2);
      key(o + 4'h2);
      key(`KPOMC_K_MODE);
    end
  endtask
  // pulse counters and hang guard
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (joint_evt_o === 1'b1) nj = nj + 1;
    if (cmd_evt_o === 1'b1) nc = nc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      wrap_up;
    end
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("speed", 5, speed_o);
    chk("lights", 0, {mode_led_o, enter_led_o, move_mode_o});
    wb(0, `KPOMC_OFS_STATUS, 0);
    chk("status", 32'h500, q);
    wb(0, 4'h6, 0);
    chk("unmapped", 0, q);
    $display("end reset test");
    n0 = nj;
    u_op.press(4'h6, 90);
    chk("joint n", n0 + 1, nj);
    chk("joint key", 6, joint_key_o);
    key(`KPOMC_K_REC);
    chk("rec key", 1, joint_key_o);
    wb_sel_i <= 4'hE;
    wb(1, `KPOMC_OFS_CTRL, 0);
    wb(0, `KPOMC_OFS_CTRL, 0);
    chk("sel lane", 1, q);
    wb_sel_i <= 4'hF;
    wb(1, `KPOMC_OFS_CTRL, 0);
    wb(0, `KPOMC_OFS_CTRL, 0);
    chk("ctrl off", 0, q);
    key(4'h6);
    chk("disabled", n0 + 2, nj);
    wb(1, `KPOMC_OFS_CTRL, 1);
    $display("end train test");
    key(`KPOMC_K_MODE);
    chk("mode led", 1, mode_led_o);
    n0 = nj;
    key(`KPOMC_C_STEP);
    chk("step", {4'h3, 1'b0}, {cmd_code_o, nj != n0});
    for (i = 0; i < 3; i = i + 1) begin
      key(ecmd[i*4 +: 4]);
      chk("enter led", 2'b01, {mode_led_o, enter_led_o});
      key(4'h3);
      key(`KPOMC_K_MODE);
      chk("entry cmd", ecmd[i*4 +: 4], cmd_code_o);
    end
    key(`KPOMC_C_SPEED);
    key(4'h3);
    key(4'h4);
    wb(0, `KPOMC_OFS_VALUE, 0);
    chk("value", 12, q);
    key(`KPOMC_K_REC);
    wb(0, `KPOMC_OFS_VALUE, 0);
    chk("cleared", 0, q);
    key(4'h3);
    key(4'h4);
    key(`KPOMC_K_MODE);
    chk("speed cmd", {4'h9, 8'h0C, 4'hC, 2'b10}, {cmd_code_o, cmd_value_o, speed_o,
      mode_led_o, enter_led_o});
    spd(1, 5);
    chk("speed 15", 15, speed_o);
    spd(1, 6);
    chk("speed 16", 15, speed_o);
    key(`KPOMC_C_JUMP);
    key(4'h3);
    key(`KPOMC_K_MODE);
    chk("jump 1", {4'hF, 8'h01, 1'b1}, {cmd_code_o, cmd_value_o, enter_led_o});
    key(4'h4);
    key(`KPOMC_K_MODE);
    chk("jump 2", {4'h8, 8'h02, 1'b0}, {cmd_code_o, cmd_value_o, enter_led_o});
    key(`KPOMC_C_RUN);
    wb(0, `KPOMC_OFS_STATUS, 0);
    chk("run", 32'hF04, q);
    key(4'h6);
    key(`KPOMC_C_STOP);
    chk("stop", {4'hD, 1'b1}, {cmd_code_o, mode_led_o});
    key(`KPOMC_C_CLEAR);
    chk("bare clr", 4'hD, cmd_code_o);
    u_op.chord(`KPOMC_C_CLEAR);
    chk("clear", 4'hB, cmd_code_o);
    u_op.chord(`KPOMC_C_ZERO);
    chk("zero", 4'hC, cmd_code_o);
    key(`KPOMC_C_TRAIN);
    chk("train", {4'h2, 3'b000}, {cmd_code_o, mode_led_o, enter_led_o, move_mode_o});
    chk("cmd n", 14, nc);
    key(`KPOMC_K_MODE);
    $display("end command test");
    key(`KPOMC_C_MOVE);
    key(4'h2);
    chk("move", {1'b1, 4'h2}, {move_mode_o, joint_key_o});
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("re-reset", {4'h5, 1'b0}, {speed_o, move_mode_o});
    $display("end move test");
    wrap_up;
  end
endmodule // kpomc_top_tb
